// *** mstat_counters.sv ***
// mac statistics counters with apb register access
// ============================================================
// Functional notes
// RULE1: counter width is a build parameter, 32 or 64, default 64.
// RULE2: a 64-bit counter is read as two 32-bit words.
// RULE3: reading a lower word snapshots that counter's upper 32 bits.
// RULE4: upper word read after lower returns the snapshot, not live bits.
// RULE5: upper read of a different counter than snapshotted answers an error.
// RULE6: received bytes counter at 0x200 adds each received frame length.
// RULE7: transmitted bytes counter at 0x208 adds each transmitted frame length.
// RULE8: undersize counter at 0x210 counts short frames with good check sequence.
// RULE9: fragment counter at 0x218 counts short frames with bad check sequence.
// RULE10: lower word at base, upper at base plus four, only when 64-bit.
// RULE11: counters clear on reset and wrap to zero past their maximum.
`timescale 1ns/1ns
module mstat_counters #(
  parameter int unsigned CNT_WIDTH = 64
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [mstat_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [mstat_pkg::DATA_W-1:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [mstat_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic irq_out,
  input wire logic rx_frame_valid_in,
  input wire logic [mstat_pkg::LEN_W-1:0] rx_frame_len_in,
  input wire logic rx_fcs_ok_in,
  input wire logic rx_frame_err_in,
  input wire logic tx_frame_valid_in,
  input wire logic [mstat_pkg::LEN_W-1:0] tx_frame_len_in
);
  import mstat_pkg::*;

  // RULE1: upper words exist only in the wide build
  localparam bit HAS_UPPER = (CNT_WIDTH > WORD_W);

  // ==========================================================
  // declarations
  logic [NUM_CNT-1:0] inc_valid;
  logic [LEN_W-1:0] inc_amount [NUM_CNT];
  logic [NUM_CNT-1:0] wrap;
  logic [CNT_WIDTH-1:0] cnt [NUM_CNT];
  logic [WORD_W-1:0] cnt_lo [NUM_CNT];
  logic [WORD_W-1:0] cnt_hi [NUM_CNT];
  logic rx_short;
  logic short_good;
  logic short_bad;
  logic [1:0] a_idx;
  logic a_aligned;
  logic a_in_page;
  logic a_lo_rd;
  logic a_hi_rd;
  logic a_status;
  logic a_mask;
  logic snap_hit;
  logic [WORD_W-1:0] hi_sel;
  logic bus_take;
  logic bus_done;
  logic order_err_evt;
  logic [DATA_W-1:0] rd_data_next;
  logic rd_err_next;
  logic [IRQ_W-1:0] w1c;
  mstat_bus_e bus_state_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic pslverr_reg;
  logic [WORD_W-1:0] snap_reg;
  logic [1:0] snap_idx_reg;
  logic snap_valid_reg;
  logic [IRQ_W-1:0] status_reg;
  logic [IRQ_W-1:0] mask_reg;

  // ==========================================================
  // frame classification
  assign rx_short = rx_frame_len_in < MIN_FRAME_LEN;
  // RULE8: short, good check sequence, no other fault
  assign short_good = rx_frame_valid_in & rx_short & rx_fcs_ok_in & ~rx_frame_err_in;
  // RULE9: short with a bad check sequence
  assign short_bad = rx_frame_valid_in & rx_short & ~rx_fcs_ok_in;

  always_comb begin
    // RULE6: received length covers address through check sequence
    inc_valid[IDX_RX_BYTES] = rx_frame_valid_in;
    inc_amount[IDX_RX_BYTES] = rx_frame_len_in;
    // RULE7: transmitted length likewise
    inc_valid[IDX_TX_BYTES] = tx_frame_valid_in;
    inc_amount[IDX_TX_BYTES] = tx_frame_len_in;
    inc_valid[IDX_SHORT_GOOD] = short_good;
    inc_amount[IDX_SHORT_GOOD] = ONE_EVENT;
    inc_valid[IDX_SHORT_BAD] = short_bad;
    inc_amount[IDX_SHORT_BAD] = ONE_EVENT;
  end

  // ==========================================================
  // counters
  for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
    // RULE11: reset to zero, wrap past maximum
    mstat_counter #(
      .W(CNT_WIDTH)
    ) u_cnt (
      .clk_sys_in(clk_sys_in),
      .nrst_in(nrst_in),
      .clk_en_in(clk_en_in),
      .inc_valid_in(inc_valid[i]),
      .inc_amount_in(inc_amount[i]),
      .count_out(cnt[i]),
      .wrap_out(wrap[i])
    );
    assign cnt_lo[i] = cnt[i][WORD_W-1:0];
    // RULE2: wide counter split into two words
    if (HAS_UPPER) begin : g_hi
      assign cnt_hi[i] = cnt[i][CNT_WIDTH-1:WORD_W];
    end else begin : g_nohi
      assign cnt_hi[i] = '0;
    end
  end

  // ==========================================================
  // address decode
  assign a_idx = paddr_in[IDX_MSB:IDX_LSB];
  assign a_aligned = paddr_in[HALF_BIT-1:0] == ALIGN_OK;
  assign a_in_page = a_aligned & (paddr_in[ADDR_W-1:PAGE_LSB] == STAT_PAGE);
  // RULE10: lower word at base, upper at base plus four
  assign a_lo_rd = a_in_page & ~paddr_in[HALF_BIT];
  assign a_hi_rd = a_in_page & paddr_in[HALF_BIT] & HAS_UPPER;
  assign a_status = paddr_in == ADDR_IRQ_STATUS;
  assign a_mask = paddr_in == ADDR_IRQ_MASK;
  assign snap_hit = snap_valid_reg & (snap_idx_reg == a_idx);
  assign hi_sel = cnt_hi[a_idx];

  // request is latched once, answered one cycle later
  assign bus_take = clk_en_in & psel_in & (bus_state_reg == BUS_IDLE);
  assign pready_out = clk_en_in & psel_in & penable_in & (bus_state_reg == BUS_READY);
  assign bus_done = pready_out;
  assign prdata_out = prdata_reg;
  assign pslverr_out = pslverr_reg & pready_out;

  always_comb begin
    rd_data_next = '0;
    rd_err_next = 1'b0;
    if (pwrite_in) begin
      // counters are read only; only the interrupt pair takes writes
      rd_err_next = ~(a_status | a_mask);
    end else if (a_lo_rd) begin
      rd_data_next = cnt_lo[a_idx];
    end else if (a_hi_rd) begin
      // RULE4: upper read returns the sampled value
      if (snap_hit) begin
        rd_data_next = snap_reg;
      end else begin
        // RULE5: mismatched upper read answers an error
        rd_err_next = 1'b1;
      end
    end else if (a_status) begin
      rd_data_next = {{(DATA_W - IRQ_W){1'b0}}, status_reg};
    end else if (a_mask) begin
      rd_data_next = {{(DATA_W - IRQ_W){1'b0}}, mask_reg};
    end else begin
      rd_err_next = 1'b1;
    end
  end

  // ==========================================================
  // bus answer
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bus_state_reg <= BUS_IDLE;
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else if (clk_en_in) begin
      case (bus_state_reg)
        BUS_IDLE: begin
          if (bus_take) begin
            prdata_reg <= rd_data_next;
            pslverr_reg <= rd_err_next;
            bus_state_reg <= BUS_READY;
          end
        end
        BUS_READY: begin
          if (bus_done) begin
            bus_state_reg <= BUS_IDLE;
          end
        end
        default: begin
          bus_state_reg <= BUS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // upper word snapshot
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      snap_reg <= '0;
      snap_idx_reg <= '0;
      snap_valid_reg <= 1'b0;
    end else if (clk_en_in) begin
      // RULE3: sample upper bits in the same edge as the lower word
      if (bus_take && !pwrite_in && a_lo_rd) begin
        snap_reg <= hi_sel;
        snap_idx_reg <= a_idx;
        snap_valid_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // interrupts
  assign order_err_evt = bus_take & ~pwrite_in & a_hi_rd & ~snap_hit;
  assign w1c = (bus_done && pwrite_in && a_status && pstrb_in[0]) ?
    pwdata_in[IRQ_W-1:0] : '0;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_reg <= IRQ_STATUS_RST;
    end else if (clk_en_in) begin
      // a new event wins over a clear in the same cycle
      status_reg <= (status_reg & ~w1c) | {order_err_evt, wrap};
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mask_reg <= IRQ_MASK_RST;
    end else if (clk_en_in && bus_done && pwrite_in && a_mask && pstrb_in[0]) begin
      mask_reg <= pwdata_in[IRQ_W-1:0];
    end
  end

  assign irq_out = |(status_reg & mask_reg);

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_lo_take;
    bus_take && !pwrite_in && a_lo_rd;
  endsequence

  sequence s_hi_match;
    bus_take && !pwrite_in && a_hi_rd && snap_hit;
  endsequence

  sequence s_hi_miss;
    bus_take && !pwrite_in && a_hi_rd && !snap_hit;
  endsequence

  property p_rx_bytes;
    (clk_en_in && rx_frame_valid_in) |=>
      cnt[IDX_RX_BYTES] == $past(cnt[IDX_RX_BYTES]) + CNT_WIDTH'($past(rx_frame_len_in));
  endproperty
  a_rx_bytes: assert property (p_rx_bytes) // RULE6
    else $error("rx byte count did not add frame length");

  property p_tx_bytes;
    (clk_en_in && tx_frame_valid_in) |=>
      cnt[IDX_TX_BYTES] == $past(cnt[IDX_TX_BYTES]) + CNT_WIDTH'($past(tx_frame_len_in));
  endproperty
  a_tx_bytes: assert property (p_tx_bytes) // RULE7
    else $error("tx byte count did not add frame length");

  property p_short_good;
    (clk_en_in && rx_frame_valid_in && rx_frame_len_in < MIN_FRAME_LEN && rx_fcs_ok_in
      && !rx_frame_err_in) |=> cnt[IDX_SHORT_GOOD] == $past(cnt[IDX_SHORT_GOOD]) + 1'b1;
  endproperty
  a_short_good: assert property (p_short_good) // RULE8
    else $error("undersize count missed a short good frame");

  property p_short_good_hold;
    !(clk_en_in && short_good) |=> $stable(cnt[IDX_SHORT_GOOD]);
  endproperty
  a_short_good_hold: assert property (p_short_good_hold) // RULE8
    else $error("undersize count moved without a short good frame");

  property p_short_bad;
    (clk_en_in && rx_frame_valid_in && rx_frame_len_in < MIN_FRAME_LEN && !rx_fcs_ok_in)
      |=> cnt[IDX_SHORT_BAD] == $past(cnt[IDX_SHORT_BAD]) + 1'b1;
  endproperty
  a_short_bad: assert property (p_short_bad) // RULE9
    else $error("fragment count missed a short bad frame");

  // reachable in the narrow build, where the byte count passes its top within a run
  property p_wrap;
    (clk_en_in && rx_frame_valid_in && cnt[IDX_RX_BYTES] > ~(CNT_WIDTH'(rx_frame_len_in)))
      |=> cnt[IDX_RX_BYTES] < CNT_WIDTH'($past(rx_frame_len_in)) && status_reg[IDX_RX_BYTES];
  endproperty
  a_wrap: assert property (p_wrap) // RULE11
    else $error("rx byte count did not wrap past its maximum");

  property p_snap;
    s_lo_take |=> snap_valid_reg && snap_reg == $past(hi_sel) && snap_idx_reg == $past(a_idx);
  endproperty
  a_snap: assert property (p_snap) // RULE3
    else $error("lower read did not sample the upper word");

  property p_hi_match;
    s_hi_match |=> prdata_out == $past(snap_reg) && !pslverr_reg;
  endproperty
  a_hi_match: assert property (p_hi_match) // RULE4
    else $error("upper read did not return the snapshot");

  property p_hi_miss;
    s_hi_miss ##1 pready_out |-> pslverr_out;
  endproperty
  a_hi_miss: assert property (p_hi_miss) // RULE5
    else $error("mismatched upper read was not refused");
endmodule : mstat_counters

// *** mstat_pkg.sv ***
// constants shared by the mac statistics counter block
package mstat_pkg;
  // ==========================================================
  // bus and datapath widths
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned LEN_W = 16;
  localparam int unsigned NUM_CNT = 4;
  localparam int unsigned IRQ_W = 5;
  // ==========================================================
  // register map
  localparam logic [ADDR_W-1:0] ADDR_RX_BYTE_LO = 12'h200;
  localparam logic [ADDR_W-1:0] ADDR_RX_BYTE_HI = 12'h204;
  localparam logic [ADDR_W-1:0] ADDR_TX_BYTE_LO = 12'h208;
  localparam logic [ADDR_W-1:0] ADDR_TX_BYTE_HI = 12'h20c;
  localparam logic [ADDR_W-1:0] ADDR_SHORT_GOOD_LO = 12'h210;
  localparam logic [ADDR_W-1:0] ADDR_SHORT_GOOD_HI = 12'h214;
  localparam logic [ADDR_W-1:0] ADDR_SHORT_BAD_LO = 12'h218;
  localparam logic [ADDR_W-1:0] ADDR_SHORT_BAD_HI = 12'h21c;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 12'h370;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h374;
  // ==========================================================
  // address fields of the counter page
  localparam int unsigned PAGE_LSB = 5;
  localparam logic [ADDR_W-PAGE_LSB-1:0] STAT_PAGE = 7'h10;
  localparam int unsigned IDX_MSB = 4;
  localparam int unsigned IDX_LSB = 3;
  localparam int unsigned HALF_BIT = 2;
  localparam logic [1:0] ALIGN_OK = 2'h0;
  // ==========================================================
  // counter indices and interrupt bits
  localparam logic [1:0] IDX_RX_BYTES = 2'h0;
  localparam logic [1:0] IDX_TX_BYTES = 2'h1;
  localparam logic [1:0] IDX_SHORT_GOOD = 2'h2;
  localparam logic [1:0] IDX_SHORT_BAD = 2'h3;
  localparam int unsigned IRQ_ORDER_BIT = 4;
  localparam logic [IRQ_W-1:0] IRQ_STATUS_RST = 5'h00;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;
  // ==========================================================
  // frame figures
  localparam logic [LEN_W-1:0] MIN_FRAME_LEN = 16'h0040;
  localparam logic [LEN_W-1:0] ONE_EVENT = 16'h0001;
  // ==========================================================
  // bus answer state
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_READY = 1'b1
  } mstat_bus_e;
endpackage : mstat_pkg

// *** mstat_counter.sv ***
// one wrapping statistics counter with a wrap strobe
`timescale 1ns/1ns
module mstat_counter #(
  parameter int unsigned W = 64
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  input wire logic inc_valid_in,
  input wire logic [mstat_pkg::LEN_W-1:0] inc_amount_in,
  output logic [W-1:0] count_out,
  output logic wrap_out
);
  import mstat_pkg::*;

  logic [W-1:0] count_reg;
  logic [W:0] sum;

  assign sum = {1'b0, count_reg} + {{(W + 1 - LEN_W){1'b0}}, inc_amount_in};
  // carry out of the top bit marks the wrap
  assign wrap_out = inc_valid_in & sum[W];
  assign count_out = count_reg;

  // ==========================================================
  // count
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_reg <= '0;
    end else if (clk_en_in && inc_valid_in) begin
      count_reg <= sum[W-1:0];
    end
  end
endmodule : mstat_counter

// *** mstat_counters_test.sv ***
// self-checking testbench for the mac statistics counters
`timescale 1ns/1ns
module mstat_counters_test;
  import mstat_pkg::*;
  logic clk_sys_in, nrst_in, clk_en_in, psel_in, penable_in, pwrite_in;
  logic [ADDR_W-1:0] paddr_in;
  logic [DATA_W-1:0] pwdata_in, prdata_out, rd;
  logic [DATA_W-1:0] rd32, prdata32;
  logic pslverr32, err32;
  logic [3:0] pstrb_in;
  logic pready_out, pslverr_out, irq_out, err;
  logic rx_frame_valid_in, rx_fcs_ok_in, rx_frame_err_in, tx_frame_valid_in;
  logic [LEN_W-1:0] rx_frame_len_in, tx_frame_len_in;
  logic [63:0] exp_rx, exp_tx, exp_good, exp_bad;
  int mismatches, total_checks;

  mstat_counters #(.CNT_WIDTH(64)) dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .clk_en_in(clk_en_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .irq_out(irq_out), .rx_frame_valid_in(rx_frame_valid_in),
    .rx_frame_len_in(rx_frame_len_in), .rx_fcs_ok_in(rx_fcs_ok_in),
    .rx_frame_err_in(rx_frame_err_in), .tx_frame_valid_in(tx_frame_valid_in),
    .tx_frame_len_in(tx_frame_len_in));

  // narrow build shares every input and answers in lockstep with dut
  mstat_counters #(.CNT_WIDTH(32)) dut_narrow (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .clk_en_in(clk_en_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pstrb_in(pstrb_in), .prdata_out(prdata32), .pready_out(),
    .pslverr_out(pslverr32), .irq_out(), .rx_frame_valid_in(rx_frame_valid_in),
    .rx_frame_len_in(rx_frame_len_in), .rx_fcs_ok_in(rx_fcs_ok_in),
    .rx_frame_err_in(rx_frame_err_in), .tx_frame_valid_in(tx_frame_valid_in),
    .tx_frame_len_in(tx_frame_len_in));

  // ==========================================================
  // compare and report
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_flag

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  // ==========================================================
  // apb master: request held until pready is sampled high
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready_out !== 1'b1 && n < 40);
    chk_flag(pready_out, 1'b1, "pready");
    rd = prdata_out;
    err = pslverr_out;
    rd32 = prdata32;
    err32 = pslverr32;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk_word(rd, exp, "read data");
    chk_flag(err, e, "slave error");
  endtask : rd_chk

  // lower word first, then upper word at base plus four
  task automatic chk_cnt(input logic [ADDR_W-1:0] base, input logic [63:0] exp);
    rd_chk(base, exp[31:0], 1'b0);
    rd_chk(base + 12'h004, exp[63:32], 1'b0);
  endtask : chk_cnt

  task automatic frame(input logic rv, input logic [15:0] rl, input logic ok, input logic fe,
                       input logic tv, input logic [15:0] tl);
    @(posedge clk_sys_in);
    rx_frame_valid_in <= rv;
    rx_frame_len_in <= rl;
    rx_fcs_ok_in <= ok;
    rx_frame_err_in <= fe;
    tx_frame_valid_in <= tv;
    tx_frame_len_in <= tl;
    @(posedge clk_sys_in);
    rx_frame_valid_in <= 1'b0;
    tx_frame_valid_in <= 1'b0;
    if (rv) begin
      exp_rx += 64'(rl);
      exp_good += 64'(rl < 16'd64 && ok && !fe);
      exp_bad += 64'(rl < 16'd64 && !ok);
    end
    if (tv) begin
      exp_tx += 64'(tl);
    end
  endtask : frame

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd_chk(ADDR_IRQ_STATUS, 32'h0, 1'b0);
    rd_chk(ADDR_IRQ_MASK, 32'h0, 1'b0);
    rd_chk(ADDR_RX_BYTE_HI, 32'h0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      chk_cnt(ADDR_RX_BYTE_LO + 12'(8 * i), 64'h0);
    end
  endtask : t_reset

  task automatic t_frames;
    frame(1'b1, 16'd40, 1'b1, 1'b0, 1'b1, 16'd1518);
    frame(1'b1, 16'd64, 1'b1, 1'b0, 1'b0, 16'd0);
    frame(1'b1, 16'd63, 1'b0, 1'b0, 1'b1, 16'd60);
    frame(1'b1, 16'd30, 1'b1, 1'b1, 1'b0, 16'd0);
    frame(1'b1, 16'd20, 1'b0, 1'b1, 1'b1, 16'd64);
    chk_cnt(ADDR_RX_BYTE_LO, exp_rx);
    chk_cnt(ADDR_TX_BYTE_LO, exp_tx);
    chk_cnt(ADDR_SHORT_GOOD_LO, exp_good);
    chk_cnt(ADDR_SHORT_BAD_LO, exp_bad);
  endtask : t_frames

  // an upper read after the carry still returns the snapshot taken by the earlier lower read
  task automatic t_snapshot;
    rd_chk(ADDR_RX_BYTE_LO, exp_rx[31:0], 1'b0);
    @(posedge clk_sys_in);
    rx_frame_valid_in <= 1'b1;
    rx_frame_len_in <= 16'hffff;
    rx_fcs_ok_in <= 1'b1;
    rx_frame_err_in <= 1'b0;
    repeat (65538) @(posedge clk_sys_in);
    rx_frame_valid_in <= 1'b0;
    exp_rx += 64'd65538 * 64'd65535;
    rd_chk(ADDR_RX_BYTE_HI, 32'h0, 1'b0);
    chk_cnt(ADDR_RX_BYTE_LO, exp_rx);
    chk_word(exp_rx[63:32], 32'h1, "carry reached upper word");
  endtask : t_snapshot

  // the narrow build has no upper words and has wrapped once by now
  task automatic t_narrow;
    rd_chk(ADDR_RX_BYTE_LO, exp_rx[31:0], 1'b0);
    chk_word(rd32, exp_rx[31:0], "narrow lower word");
    rd_chk(ADDR_RX_BYTE_HI, exp_rx[63:32], 1'b0);
    chk_flag(err32, 1'b1, "narrow upper word");
    rd_chk(ADDR_IRQ_STATUS, 32'h10, 1'b0);
    chk_word(rd32, 32'h1, "narrow wrap status");
  endtask : t_narrow

  // a frame pulse while the clock enable is low is lost
  task automatic t_freeze;
    @(posedge clk_sys_in);
    clk_en_in <= 1'b0;
    rx_frame_valid_in <= 1'b1;
    rx_frame_len_in <= 16'd40;
    rx_fcs_ok_in <= 1'b1;
    rx_frame_err_in <= 1'b0;
    @(posedge clk_sys_in);
    rx_frame_valid_in <= 1'b0;
    clk_en_in <= 1'b1;
    chk_cnt(ADDR_RX_BYTE_LO, exp_rx);
    chk_cnt(ADDR_SHORT_GOOD_LO, exp_good);
  endtask : t_freeze

  // reset in mid-run clears counters, snapshot, status and mask
  task automatic t_rst_again;
    @(posedge clk_sys_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    #1 chk_flag(irq_out, 1'b0, "irq in reset");
    chk_flag(pslverr_out, 1'b0, "error in reset");
    chk_word(prdata_out, 32'h0, "read data in reset");
    @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    {exp_rx, exp_tx, exp_good, exp_bad} = '0;
    t_reset();
  endtask : t_rst_again

  task automatic t_refused;
    rd_chk(ADDR_RX_BYTE_LO, exp_rx[31:0], 1'b0);
    rd_chk(ADDR_TX_BYTE_HI, 32'h0, 1'b1);
    rd_chk(ADDR_RX_BYTE_HI, exp_rx[63:32], 1'b0);
    apb(1'b1, ADDR_TX_BYTE_LO, 32'hffffffff);
    chk_flag(err, 1'b1, "counter write");
    chk_cnt(ADDR_TX_BYTE_LO, exp_tx);
    rd_chk(12'h100, 32'h0, 1'b1);
    apb(1'b0, 12'h202, 32'h0);
    chk_flag(err, 1'b1, "misaligned");
  endtask : t_refused

  // status bit 4 is already set by the refused upper reads before
  task automatic t_irq;
    apb(1'b1, ADDR_IRQ_MASK, 32'h10);
    #1 chk_flag(irq_out, 1'b1, "irq unmasked");
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    #1 chk_flag(irq_out, 1'b0, "irq masked");
    apb(1'b1, ADDR_IRQ_STATUS, 32'h10);
    rd_chk(ADDR_IRQ_STATUS, 32'h0, 1'b0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h10);
    #1 chk_flag(irq_out, 1'b0, "irq after clear");
    rd_chk(ADDR_SHORT_GOOD_HI, 32'h0, 1'b1);
    #1 chk_flag(irq_out, 1'b1, "irq on refusal");
    rd_chk(ADDR_IRQ_STATUS, 32'h10, 1'b0);
    // a write without its low byte strobe leaves the mask alone
    pstrb_in <= 4'h0;
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    pstrb_in <= 4'hf;
    rd_chk(ADDR_IRQ_MASK, 32'h10, 1'b0);
  endtask : t_irq

  // ==========================================================
  // clock, reset, sequence and watchdog
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    {nrst_in, psel_in, penable_in, pwrite_in, rx_frame_valid_in, tx_frame_valid_in} = '0;
    {rx_fcs_ok_in, rx_frame_err_in} = '0;
    clk_en_in = 1'b1;
    pstrb_in = 4'hf;
    paddr_in = '0;
    pwdata_in = '0;
    rx_frame_len_in = '0;
    tx_frame_len_in = '0;
    {exp_rx, exp_tx, exp_good, exp_bad} = '0;
    repeat (6) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    t_reset();
    t_frames();
    t_freeze();
    t_snapshot();
    t_narrow();
    t_refused();
    t_irq();
    t_rst_again();
    close_out();
  end

  initial begin
    repeat (90000) @(posedge clk_sys_in);
    mismatches++;
    close_out();
  end
endmodule : mstat_counters_test
